// ---- logic/smc_sleep_ctrl.sv ----
`timescale 1ns/10ps
// ============================================================
// Sleep-mode controller: gates clock domains and sequences wake-up.

module smc_sleep_ctrl #(
  parameter int XTAL_START = smc_pkg::XTAL_START_CYC,
  parameter int EXT_IRQ_W = 4
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Link to the processor core.
  smc_link_if.device link,
  // Clock source configuration.
  input wire logic [3:0] clockSourceFuses,
  input wire logic crystalSel,
  // Peripheral state and wake sources on the core clock.
  input wire logic adcEnabled,
  input wire logic adcDone,
  input wire logic twiAddrMatch,
  input wire logic tmr0Ovf,
  input wire logic tmr0Cmp,
  input wire logic nvReady,
  input wire logic wdtReset,
  input wire logic bodReset,
  // Asynchronous pins.
  input wire logic [EXT_IRQ_W-1:0] extIrqLo,
  input wire logic [EXT_IRQ_W-1:0] extIrqHi,
  input wire logic extResetPin,
  // Clock gate enables and converter start.
  output logic coreClkEn,
  output logic flashClkEn,
  output logic ioClkEn,
  output logic adcClkEn,
  output logic asyncClkEn,
  output logic oscEn,
  output logic adcStart
);
  localparam int SYNC_W = 2 * EXT_IRQ_W + 1;
  localparam logic [smc_pkg::CNT_W-1:0] ONE = 16'h0001;

  smc_pkg::smc_state_t stateReg, stateNext;
  logic [2:0] modeReg, modeNext;
  logic [2:0] effKind;
  logic [smc_pkg::CNT_W-1:0] cntReg, cntNext, startCnt;
  logic rstWakeReg, rstWakeNext;
  logic adcStartReg, adcStartNext;
  logic resumeIrqReg, resumeIrqNext;
  logic resumeRstReg, resumeRstNext;
  logic nopReg, nopNext;
  logic haltReg, haltNext;
  logic [5:0] gateReg, gateNext;
  logic [SYNC_W-1:0] pinSync;
  logic extWake, tmrEvt, srcWake, resetWake;

  // ============================================================
  // Pin synchronisation; level interrupts are seen only after two stages.
  smc_sync #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pinIn({extResetPin, extIrqHi, extIrqLo}),
    .syncOut(pinSync)
  );

  // ============================================================
  // Wake source qualification per latched sleep kind.
  always_comb begin
    extWake = |pinSync[2*EXT_IRQ_W-1:0];
    tmrEvt = ((tmr0Ovf && link.timerIrqMask[smc_pkg::POS_TMR_OVF_EN]) ||
              (tmr0Cmp && link.timerIrqMask[smc_pkg::POS_TMR_CMP_EN])) && link.globalIrqEn;
    resetWake = pinSync[SYNC_W-1] || wdtReset || bodReset;
    case (modeReg)
      smc_pkg::KIND_IDLE: srcWake = link.irqPending;
      smc_pkg::KIND_NOISE: srcWake = adcDone || extWake || twiAddrMatch || tmrEvt || nvReady;
      smc_pkg::KIND_PDOWN: srcWake = extWake || twiAddrMatch;
      smc_pkg::KIND_STBY: srcWake = extWake || twiAddrMatch;
      smc_pkg::KIND_PSAVE: srcWake = extWake || twiAddrMatch || (tmrEvt && link.tmr0ExtclkSelect);
      smc_pkg::KIND_XSTBY: srcWake = extWake || twiAddrMatch || (tmrEvt && link.tmr0ExtclkSelect);
      default: srcWake = link.irqPending;
    endcase
  end

  // Kind decode; reserved codes and standby without a crystal fold into Idle.
  always_comb begin
    case (link.sleepKindSel)
      smc_pkg::KIND_NOISE, smc_pkg::KIND_PDOWN, smc_pkg::KIND_PSAVE: effKind = link.sleepKindSel;
      smc_pkg::KIND_STBY, smc_pkg::KIND_XSTBY: effKind = crystalSel ? link.sleepKindSel : smc_pkg::KIND_IDLE;
      default: effKind = smc_pkg::KIND_IDLE;
    endcase
  end

  // Clock restart time once a wake is seen; Idle and noise reduction need none.
  always_comb begin
    case (modeReg)
      smc_pkg::KIND_PDOWN, smc_pkg::KIND_PSAVE: begin
        if (clockSourceFuses == smc_pkg::FUSE_EXTCLK) begin
          startCnt = smc_pkg::CNT_W'(smc_pkg::EXTCLK_START_CYC);
        end else begin
          startCnt = smc_pkg::CNT_W'(XTAL_START);
        end
      end
      smc_pkg::KIND_STBY, smc_pkg::KIND_XSTBY: startCnt = smc_pkg::CNT_W'(smc_pkg::STBY_WAKE_CYC);
      default: startCnt = '0;
    endcase
  end

  // ============================================================
  // Sequencer next state.
  always_comb begin
    stateNext = stateReg;
    modeNext = modeReg;
    cntNext = cntReg;
    rstWakeNext = rstWakeReg;
    adcStartNext = 1'b0;
    resumeIrqNext = 1'b0;
    resumeRstNext = 1'b0;
    nopNext = 1'b0;
    case (stateReg)
      smc_pkg::ST_RUN: begin
        if (link.sleepReq && link.sleepArm) begin
          modeNext = effKind;
          stateNext = smc_pkg::ST_SLEEP;
          adcStartNext = adcEnabled && (effKind == smc_pkg::KIND_IDLE || effKind == smc_pkg::KIND_NOISE);
        end else if (link.sleepReq) begin
          nopNext = 1'b1;
        end
      end
      smc_pkg::ST_SLEEP: begin
        if (resetWake || srcWake) begin
          rstWakeNext = resetWake;
          if (startCnt == '0) begin
            stateNext = smc_pkg::ST_HALT;
            cntNext = smc_pkg::CNT_W'(smc_pkg::HALT_CYC);
          end else begin
            stateNext = smc_pkg::ST_START;
            cntNext = startCnt;
          end
        end
      end
      smc_pkg::ST_START: begin
        if (cntReg == ONE) begin
          stateNext = smc_pkg::ST_HALT;
          cntNext = smc_pkg::CNT_W'(smc_pkg::HALT_CYC);
        end else begin
          cntNext = cntReg - ONE;
        end
      end
      smc_pkg::ST_HALT: begin
        if (cntReg == ONE) begin
          stateNext = smc_pkg::ST_RUN;
          resumeIrqNext = !rstWakeReg;
          resumeRstNext = rstWakeReg;
          rstWakeNext = 1'b0;
        end else begin
          cntNext = cntReg - ONE;
        end
      end
      default: stateNext = smc_pkg::ST_RUN;
    endcase
    // Core stays halted outside run; Wishbone register writes at the core end still go through.
    haltNext = stateNext != smc_pkg::ST_RUN;
  end

  // Clock gates in order core, flash, io, adc, async, oscillator.
  always_comb begin
    gateNext = 6'h3F;
    if (stateNext == smc_pkg::ST_SLEEP) begin
      case (modeNext)
        smc_pkg::KIND_IDLE: gateNext = 6'h3C;
        smc_pkg::KIND_NOISE: gateNext = 6'h38;
        smc_pkg::KIND_PDOWN: gateNext = 6'h00;
        smc_pkg::KIND_PSAVE: gateNext = {1'b0, link.tmr0ExtclkSelect, 4'h0};
        smc_pkg::KIND_STBY: gateNext = 6'h20;
        smc_pkg::KIND_XSTBY: gateNext = {1'b1, link.tmr0ExtclkSelect, 4'h0};
        default: gateNext = 6'h3C;
      endcase
    end
  end

  // ============================================================
  // State registers.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= smc_pkg::ST_RUN;
      modeReg <= smc_pkg::KIND_IDLE;
      cntReg <= '0;
      rstWakeReg <= 1'b0;
      adcStartReg <= 1'b0;
      resumeIrqReg <= 1'b0;
      resumeRstReg <= 1'b0;
      nopReg <= 1'b0;
      haltReg <= 1'b0;
      gateReg <= 6'h3F;
    end else begin
      stateReg <= stateNext;
      modeReg <= modeNext;
      cntReg <= cntNext;
      rstWakeReg <= rstWakeNext;
      adcStartReg <= adcStartNext;
      resumeIrqReg <= resumeIrqNext;
      resumeRstReg <= resumeRstNext;
      nopReg <= nopNext;
      haltReg <= haltNext;
      gateReg <= gateNext;
    end
  end

  // ============================================================
  // Outputs straight from flip-flops.
  assign coreClkEn = gateReg[0];
  assign flashClkEn = gateReg[1];
  assign ioClkEn = gateReg[2];
  assign adcClkEn = gateReg[3];
  assign asyncClkEn = gateReg[4];
  assign oscEn = gateReg[5];
  assign adcStart = adcStartReg;
  assign link.coreHalt = haltReg;
  assign link.sleeping = haltReg;
  assign link.resumeIrq = resumeIrqReg;
  assign link.resumeReset = resumeRstReg;
  assign link.sleepNop = nopReg;
endmodule // smc_sleep_ctrl

// ---- logic/smc_pkg.sv ----
// ============================================================
// Shared constants and types of the sleep-mode clock controller.
package smc_pkg;

  // ============================================================
  // Sleep kind codes as written into the sleep kind field.
  localparam logic [2:0] KIND_IDLE = 3'h0;
  localparam logic [2:0] KIND_NOISE = 3'h1;
  localparam logic [2:0] KIND_PDOWN = 3'h2;
  localparam logic [2:0] KIND_PSAVE = 3'h3;
  localparam logic [2:0] KIND_STBY = 3'h6;
  localparam logic [2:0] KIND_XSTBY = 3'h7;

  // ============================================================
  // Wake timing in core clock cycles.
  localparam int HALT_CYC = 4;
  localparam int STBY_WAKE_CYC = 6;
  localparam int EXTCLK_START_CYC = 6;
  localparam int XTAL_START_CYC = 1024;
  localparam logic [3:0] FUSE_EXTCLK = 4'h0;
  localparam int CNT_W = 16;

  // ============================================================
  // Register offsets of the core end (byte addresses).
  localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMER_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_CPU_FLAGS = 8'h08;
  localparam logic [7:0] OFS_ASYNC_TIMER_CTRL = 8'h0C;
  localparam logic [7:0] OFS_COMPARATOR_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ============================================================
  // Field positions and reset values.
  localparam int POS_SLEEP_ARM = 5;
  localparam int POS_KIND_1 = 4;
  localparam int POS_KIND_0 = 3;
  localparam int POS_KIND_2 = 2;
  localparam int POS_TMR_OVF_EN = 0;
  localparam int POS_TMR_CMP_EN = 1;
  localparam int POS_GIE = 7;
  localparam int POS_TMR0_EXTCLK = 3;
  localparam int POS_COMP_OFF = 7;
  localparam int POS_ST_SLEEPING = 0;
  localparam int POS_ST_RST_WAKE = 1;
  localparam int POS_ST_NOP = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ============================================================
  // Controller states, Gray coded along run, sleep, start, halt.
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SLEEP = 2'h1,
    ST_START = 2'h3,
    ST_HALT = 2'h2
  } smc_state_t;

endpackage

// ---- logic/smc_link_if.sv ----
`timescale 1ns/10ps
// ============================================================
// Link between the processor core end and the sleep controller.
interface smc_link_if;
  logic sleepReq;
  logic sleepArm;
  logic [2:0] sleepKindSel;
  logic tmr0ExtclkSelect;
  logic [1:0] timerIrqMask;
  logic globalIrqEn;
  logic irqPending;
  logic coreHalt;
  logic sleeping;
  logic resumeIrq;
  logic resumeReset;
  logic sleepNop;

  // ============================================================
  // Controller end.
  modport device (
    input sleepReq, sleepArm, sleepKindSel, tmr0ExtclkSelect, timerIrqMask, globalIrqEn, irqPending,
    output coreHalt, sleeping, resumeIrq, resumeReset, sleepNop
  );

  // ============================================================
  // Processor core end.
  modport core (
    output sleepReq, sleepArm, sleepKindSel, tmr0ExtclkSelect, timerIrqMask, globalIrqEn, irqPending,
    input coreHalt, sleeping, resumeIrq, resumeReset, sleepNop
  );
endinterface

// ---- logic/smc_sync.sv ----
`timescale 1ns/10ps
// ============================================================
// Two-stage synchroniser for asynchronous pin levels.
module smc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Pin levels and their synchronised copies.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  genvar i;

  // One pair of flip-flops per bit.
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1Reg;
      logic stage2Reg;
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1Reg <= 1'b0;
          stage2Reg <= 1'b0;
        end else begin
          stage1Reg <= pinIn[i];
          stage2Reg <= stage1Reg;
        end
      end
      assign syncOut[i] = stage2Reg;
    end
  endgenerate
endmodule // smc_sync

// ---- logic/smc_core_end.sv ----
`timescale 1ns/10ps
// ============================================================
// Processor core end: software registers over Wishbone and sleep requests.
module smc_core_end (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core events.
  input wire logic sleepInsn,
  input wire logic irqPending,
  output logic resumeIrq,
  output logic resumeReset,
  output logic coreHalt,
  output logic comparatorOff,
  // Link to the controller.
  smc_link_if.core link
);
  logic [7:0] powerCtrlReg, powerCtrlNext;
  logic [7:0] timerMaskReg, timerMaskNext;
  logic [7:0] cpuFlagsReg, cpuFlagsNext;
  logic [7:0] asyncCtrlReg, asyncCtrlNext;
  logic [7:0] compCtrlReg, compCtrlNext;
  logic [2:0] stickyReg, stickyNext;
  logic ackReg, ackNext;
  logic [31:0] rdataReg, rdataNext;
  logic wrEn;
  logic [7:0] rdByte;

  // ============================================================
  // Register writes, read mux and sticky status; a new event beats its clear.
  always_comb begin
    powerCtrlNext = powerCtrlReg;
    timerMaskNext = timerMaskReg;
    cpuFlagsNext = cpuFlagsReg;
    asyncCtrlNext = asyncCtrlReg;
    compCtrlNext = compCtrlReg;
    stickyNext = stickyReg;
    ackNext = wb_cyc_i && wb_stb_i && !ackReg;
    wrEn = ackNext && wb_we_i && wb_sel_i[0];
    rdByte = smc_pkg::RESET_BYTE;
    case (wb_adr_i)
      smc_pkg::OFS_POWER_CTRL: rdByte = powerCtrlReg;
      smc_pkg::OFS_TIMER_IRQ_MASK: rdByte = timerMaskReg;
      smc_pkg::OFS_CPU_FLAGS: rdByte = cpuFlagsReg;
      smc_pkg::OFS_ASYNC_TIMER_CTRL: rdByte = asyncCtrlReg;
      smc_pkg::OFS_COMPARATOR_CTRL: rdByte = compCtrlReg;
      smc_pkg::OFS_STATUS: rdByte = {5'h00, stickyReg[2:1], link.sleeping};
      default: rdByte = smc_pkg::RESET_BYTE;
    endcase
    rdataNext = ackNext ? {24'h000000, rdByte} : rdataReg;
    if (wrEn) begin
      case (wb_adr_i)
        smc_pkg::OFS_POWER_CTRL: powerCtrlNext = wb_dat_i[7:0] & 8'h3C;
        smc_pkg::OFS_TIMER_IRQ_MASK: timerMaskNext = wb_dat_i[7:0] & 8'h03;
        smc_pkg::OFS_CPU_FLAGS: cpuFlagsNext = wb_dat_i[7:0];
        smc_pkg::OFS_ASYNC_TIMER_CTRL: asyncCtrlNext = wb_dat_i[7:0];
        smc_pkg::OFS_COMPARATOR_CTRL: compCtrlNext = wb_dat_i[7:0];
        smc_pkg::OFS_STATUS: stickyNext = stickyReg & ~wb_dat_i[2:0];
        default: stickyNext = stickyReg;
      endcase
    end
    if (link.resumeReset) begin
      stickyNext[smc_pkg::POS_ST_RST_WAKE] = 1'b1;
    end
    if (link.sleepNop) begin
      stickyNext[smc_pkg::POS_ST_NOP] = 1'b1;
    end
    stickyNext[smc_pkg::POS_ST_SLEEPING] = 1'b0;
  end

  // ============================================================
  // Register file.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      powerCtrlReg <= smc_pkg::RESET_BYTE;
      timerMaskReg <= smc_pkg::RESET_BYTE;
      cpuFlagsReg <= smc_pkg::RESET_BYTE;
      asyncCtrlReg <= smc_pkg::RESET_BYTE;
      compCtrlReg <= smc_pkg::RESET_BYTE;
      stickyReg <= 3'h0;
      ackReg <= 1'b0;
      rdataReg <= 32'h00000000;
    end else begin
      powerCtrlReg <= powerCtrlNext;
      timerMaskReg <= timerMaskNext;
      cpuFlagsReg <= cpuFlagsNext;
      asyncCtrlReg <= asyncCtrlNext;
      compCtrlReg <= compCtrlNext;
      stickyReg <= stickyNext;
      ackReg <= ackNext;
      rdataReg <= rdataNext;
    end
  end

  // ============================================================
  // Link drive; a sleep instruction is ignored while the core is halted.
  assign link.sleepReq = sleepInsn && !link.coreHalt;
  assign link.sleepArm = powerCtrlReg[smc_pkg::POS_SLEEP_ARM];
  assign link.sleepKindSel = {powerCtrlReg[smc_pkg::POS_KIND_2], powerCtrlReg[smc_pkg::POS_KIND_1],
                              powerCtrlReg[smc_pkg::POS_KIND_0]};
  assign link.tmr0ExtclkSelect = asyncCtrlReg[smc_pkg::POS_TMR0_EXTCLK];
  assign link.timerIrqMask = {timerMaskReg[smc_pkg::POS_TMR_CMP_EN], timerMaskReg[smc_pkg::POS_TMR_OVF_EN]};
  assign link.globalIrqEn = cpuFlagsReg[smc_pkg::POS_GIE];
  assign link.irqPending = irqPending;
  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdataReg;
  assign resumeIrq = link.resumeIrq;
  assign resumeReset = link.resumeReset;
  assign coreHalt = link.coreHalt;
  assign comparatorOff = compCtrlReg[smc_pkg::POS_COMP_OFF];
endmodule // smc_core_end

// ---- tb/smc_link_monitor.sv ----
`timescale 1ns/10ps
// ============================================================
// Concurrent checks on the link and the clock gate enables.
module smc_link_monitor (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Link signals.
  input wire logic sleepReq,
  input wire logic sleepArm,
  input wire logic [2:0] sleepKindSel,
  input wire logic tmr0ExtclkSelect,
  input wire logic coreHalt,
  input wire logic resumeIrq,
  input wire logic resumeReset,
  input wire logic sleepNop,
  // Controller configuration and outputs.
  input wire logic crystalSel,
  input wire logic adcEnabled,
  input wire logic coreClkEn,
  input wire logic flashClkEn,
  input wire logic ioClkEn,
  input wire logic adcClkEn,
  input wire logic asyncClkEn,
  input wire logic oscEn,
  input wire logic adcStart
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // A sleep request is taken only while the core runs.
  wire logic take = sleepReq && !coreHalt;
  wire logic armed = take && sleepArm;
  wire logic [5:0] gates = {oscEn, asyncClkEn, adcClkEn, ioClkEn, flashClkEn, coreClkEn};

  // ============================================================
  // Entry, gating and wake sequencing.
  a_armed_halt: assert property (armed |=> coreHalt && !sleepNop) else $error("armed sleep not halted");
  a_unarmed_nop: assert property (take && !sleepArm |=> sleepNop && !coreHalt && gates == 6'h3F)
    else $error("unarmed sleep changed state");
  a_idle_gates: assert property (armed && (sleepKindSel inside {3'h0, 3'h4, 3'h5}) |=> gates == 6'h3C)
    else $error("idle gates wrong");
  a_noise_gates: assert property (armed && sleepKindSel == smc_pkg::KIND_NOISE |=> gates == 6'h38)
    else $error("noise gates wrong");
  a_pdown_gates: assert property (armed && sleepKindSel == smc_pkg::KIND_PDOWN |=> gates == 6'h00)
    else $error("power-down gates wrong");
  a_psave_gates: assert property (
    armed && sleepKindSel == smc_pkg::KIND_PSAVE |=> gates == {1'h0, $past(tmr0ExtclkSelect), 4'h0})
    else $error("power-save gates wrong");
  a_stby_gates: assert property (
    armed && crystalSel && sleepKindSel == smc_pkg::KIND_STBY |=> gates == 6'h20)
    else $error("standby gates wrong");
  a_xstby_gates: assert property (
    armed && crystalSel && sleepKindSel == smc_pkg::KIND_XSTBY |=> gates == {1'h1, $past(tmr0ExtclkSelect), 4'h0})
    else $error("extended standby gates wrong");
  a_nocrystal_idle: assert property (armed && !crystalSel && sleepKindSel[2:1] == 2'h3 |=> gates == 6'h3C)
    else $error("standby without crystal not idle");
  a_adc_kick: assert property (armed && adcEnabled && sleepKindSel[2:1] == 2'h0 |=> adcStart)
    else $error("conversion not started");
  a_adc_quiet: assert property (adcStart |-> $past(armed && adcEnabled))
    else $error("conversion started without armed entry");
  a_halt_four: assert property (
    $fell(coreHalt) |-> $past(coreClkEn, 4) && $past(oscEn, 4) && $past(coreHalt, 4))
    else $error("halt before resume not four cycles");
  a_resume_kind: assert property (
    $fell(coreHalt) |-> (resumeIrq ^ resumeReset) ##1 !(resumeIrq || resumeReset))
    else $error("resume pulse wrong");
endmodule // smc_link_monitor

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
// ============================================================
// Both ends joined by the link, driven over Wishbone and wake inputs.
module testbench;
  typedef struct {
    logic [2:0] kind;
    logic xtal;
    logic [3:0] fuse;
    logic [1:0] mask;
    logic ext;
    logic gie;
    int src;
    int decoy;
    logic [5:0] gates;
    int dly;
    logic rst;
  } smc_case_t;

  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, resumeIrq, resumeReset, coreHalt, adcStart, compOff;
  logic coreClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, oscEn;
  logic sleepInsn = 1'h0;
  logic crystalSel = 1'h0;
  logic adcEnabled = 1'h1;
  logic [3:0] fuses = 4'h0;
  logic [8:0] src = 9'h000;
  logic [7:0] rd;
  int mismatches = 0;
  int comparisons = 0;
  wire logic [5:0] gates = {oscEn, asyncClkEn, adcClkEn, ioClkEn, flashClkEn, coreClkEn};
  // Mode, wake source, decoy that must not wake, gates and cycles from wake input to resume.
  smc_case_t cases [10] = '{
    '{3'h0, 1'h0, 4'h0, 2'h0, 1'h0, 1'h0, 0, -1, 6'h3C, 5, 1'h0},
    '{3'h1, 1'h0, 4'h0, 2'h0, 1'h0, 1'h0, 1, 0, 6'h38, 5, 1'h0},
    '{3'h2, 1'h0, 4'h0, 2'h0, 1'h0, 1'h0, 2, 0, 6'h00, 13, 1'h0},
    '{3'h2, 1'h0, 4'h1, 2'h0, 1'h0, 1'h0, 4, 1, 6'h00, 13, 1'h1},
    '{3'h3, 1'h0, 4'h0, 2'h1, 1'h1, 1'h1, 3, 8, 6'h10, 11, 1'h0},
    '{3'h6, 1'h1, 4'h0, 2'h0, 1'h0, 1'h0, 6, 0, 6'h20, 11, 1'h0},
    '{3'h7, 1'h1, 4'h0, 2'h0, 1'h0, 1'h0, 5, 7, 6'h20, 13, 1'h0},
    '{3'h7, 1'h1, 4'h0, 2'h1, 1'h1, 1'h0, 6, 3, 6'h30, 11, 1'h0},
    '{3'h4, 1'h0, 4'h0, 2'h0, 1'h0, 1'h0, 0, -1, 6'h3C, 5, 1'h0},
    '{3'h6, 1'h0, 4'h0, 2'h0, 1'h0, 1'h0, 0, -1, 6'h3C, 5, 1'h0}};

  // ============================================================
  // Design, link and checker.
  smc_link_if link ();
  smc_core_end i_smc_core_end (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .sleepInsn(sleepInsn), .irqPending(src[0]), .resumeIrq(resumeIrq), .resumeReset(resumeReset),
    .coreHalt(coreHalt), .comparatorOff(compOff), .link(link));
  smc_sleep_ctrl #(.XTAL_START(8), .EXT_IRQ_W(4)) i_smc_sleep_ctrl (.core_clk(core_clk), .reset_n(reset_n),
    .link(link), .clockSourceFuses(fuses), .crystalSel(crystalSel), .adcEnabled(adcEnabled), .adcDone(src[1]),
    .twiAddrMatch(src[6]), .tmr0Ovf(src[3]), .tmr0Cmp(src[8]), .nvReady(src[7]), .wdtReset(src[4]),
    .bodReset(1'h0), .extIrqLo({3'h0, src[2]}), .extIrqHi({2'h0, src[5], 1'h0}), .extResetPin(1'h0),
    .coreClkEn(coreClkEn), .flashClkEn(flashClkEn), .ioClkEn(ioClkEn), .adcClkEn(adcClkEn),
    .asyncClkEn(asyncClkEn), .oscEn(oscEn), .adcStart(adcStart));
  smc_link_monitor i_smc_link_monitor (.core_clk(core_clk), .reset_n(reset_n), .sleepReq(link.sleepReq),
    .sleepArm(link.sleepArm), .sleepKindSel(link.sleepKindSel), .tmr0ExtclkSelect(link.tmr0ExtclkSelect),
    .coreHalt(link.coreHalt), .resumeIrq(link.resumeIrq), .resumeReset(link.resumeReset),
    .sleepNop(link.sleepNop), .crystalSel(crystalSel), .adcEnabled(adcEnabled), .coreClkEn(coreClkEn),
    .flashClkEn(flashClkEn), .ioClkEn(ioClkEn), .adcClkEn(adcClkEn), .asyncClkEn(asyncClkEn), .oscEn(oscEn),
    .adcStart(adcStart));

  // The clock toggles every half period of 2 ns.
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // ============================================================
  // Helpers.
  function automatic logic [7:0] ctrlByte(input logic arm, input logic [2:0] k);
    return {2'h0, arm, k[1], k[0], k[2], 2'h0};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] q);
    int n;
    @(posedge core_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'h1;
    wbDatI <= {24'h0, dat};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'h1 && n < 50);
    q = wbDatO[7:0];
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    if (n >= 50) mismatches++;
  endtask

  // One sleep instruction; returns after the edge that takes it.
  task automatic sleepPulse();
    @(posedge core_clk);
    sleepInsn <= 1'h1;
    @(posedge core_clk);
    sleepInsn <= 1'h0;
    #1;
  endtask

  // Sleeps in one mode, checks decoys are ignored and times the wake.
  task automatic runCase(input smc_case_t c);
    int n;
    fuses <= c.fuse;
    crystalSel <= c.xtal;
    wbXfer(1'h1, smc_pkg::OFS_TIMER_IRQ_MASK, {6'h0, c.mask}, rd);
    wbXfer(1'h1, smc_pkg::OFS_CPU_FLAGS, {c.gie, 7'h00}, rd);
    wbXfer(1'h1, smc_pkg::OFS_ASYNC_TIMER_CTRL, {4'h0, c.ext, 3'h0}, rd);
    wbXfer(1'h1, smc_pkg::OFS_POWER_CTRL, ctrlByte(1'h1, c.kind), rd);
    sleepPulse();
    check({1'h0, coreHalt, gates}, {2'h1, c.gates});
    if (c.decoy >= 0) begin
      @(posedge core_clk);
      src[c.decoy] <= 1'h1;
      repeat (4) @(posedge core_clk);
      src[c.decoy] <= 1'h0;
      #1;
      check({7'h0, coreHalt}, 8'h01);
    end
    // The wake level is held until the core resumes.
    @(posedge core_clk);
    src[c.src] <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      #1;
    end while (resumeIrq !== 1'h1 && resumeReset !== 1'h1 && n < 100);
    check(8'(n), 8'(c.dly));
    check({7'h0, resumeReset}, {7'h0, c.rst});
    @(posedge core_clk);
    src[c.src] <= 1'h0;
    wbXfer(1'h0, smc_pkg::OFS_POWER_CTRL, 8'h00, rd);
    check(rd, ctrlByte(1'h1, c.kind));
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      wbXfer(1'h0, 8'(i * 4), 8'h00, rd);
      check(rd, smc_pkg::RESET_BYTE);
    end
    // An unmapped write is acknowledged but dropped.
    wbXfer(1'h1, 8'h40, 8'hFF, rd);
    wbXfer(1'h0, 8'h40, 8'h00, rd);
    check(rd, 8'h00);
    wbXfer(1'h1, smc_pkg::OFS_POWER_CTRL, ctrlByte(1'h0, smc_pkg::KIND_PDOWN), rd);
    sleepPulse();
    check({1'h0, coreHalt, gates}, 8'h3F);
    wbXfer(1'h0, smc_pkg::OFS_STATUS, 8'h00, rd);
    check(rd, 8'h04);
    wbXfer(1'h1, smc_pkg::OFS_STATUS, 8'h04, rd);
    wbXfer(1'h0, smc_pkg::OFS_STATUS, 8'h00, rd);
    check(rd, 8'h00);
    wbXfer(1'h1, smc_pkg::OFS_COMPARATOR_CTRL, 8'h80, rd);
    check({7'h0, compOff}, 8'h01);
    foreach (cases[i]) runCase(cases[i]);
    wrap_up();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    wrap_up();
  end
endmodule // testbench
